// [include/pwmds_pkg.sv]
// shared constants for the pwm divider duty stepper
package pwmds_pkg;
	localparam int unsigned CLK_HZ = 5000;
	localparam int unsigned DIV_W = 6;
	localparam logic [5:0] DIV_MIN = 6'h02;
	localparam int unsigned LVL_W = 4;
	localparam logic [3:0] LVL_MAX = 4'hA;
	localparam logic [3:0] LVL_RST = 4'h5;
	localparam logic [3:0] LVL_STEPS = 4'hA;
	localparam int unsigned PROD_W = 10;
	// apb register map
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_STAT = 8'h04;
	localparam int unsigned CTRL_EN_BIT = 0;
	localparam int unsigned CTRL_UP_BIT = 1;
	localparam int unsigned CTRL_DN_BIT = 2;
	localparam logic CTRL_EN_RST = 1'b1;
	localparam int unsigned STAT_LVL_LSB = 0;
	localparam int unsigned STAT_DIV_LSB = 8;
	localparam int unsigned STAT_PWM_BIT = 16;
	localparam int unsigned STAT_EN_BIT = 17;
	typedef enum logic [1:0] {
		PWMDS_IDLE = 2'b00,
		PWMDS_ACK = 2'b01
	} pwmds_apb_t;
endpackage

// [hdl/pwmds_edge.sv]
// rising-edge detector giving one pulse per press
`timescale 1ns/1ps
module pwmds_edge (
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// level in, pulse out
	input wire logic level_in,
	output logic pulse_out
);
	logic prev_r;

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			prev_r <= 1'b0;
		end else begin
			prev_r <= level_in;
		end
	end

	// held button yields a single step
	assign pulse_out = level_in & ~prev_r;
endmodule

// [hdl/pwmds_top.sv]
// pwm generator with pin divisor, duty stepping buttons and apb status
//
// Implementation choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
module pwmds_top (
	// clock and reset
	input wire logic core_clk_in,
	input wire logic rst_in,
	// user pins
	input wire logic step_up_in,
	input wire logic step_down_in,
	input wire logic [5:0] divisor_in,
	// pwm output
	output logic pwm_out,
	// apb slave
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [7:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out
);
	logic [5:0] cnt_r;
	logic [5:0] cnt_nxt;
	logic [3:0] lvl_r;
	logic [3:0] lvl_nxt;
	logic pwm_r;
	logic en_r;
	logic [31:0] prdata_r;
	logic pslverr_r;
	pwmds_pkg::pwmds_apb_t apb_r;
	pwmds_pkg::pwmds_apb_t apb_nxt;
	logic up_pulse;
	logic dn_pulse;
	logic [5:0] div_eff;
	logic cnt_wrap;
	logic [9:0] phase_x10;
	logic [9:0] high_lim;
	logic pwm_nxt;
	logic acc;
	logic wr_take;
	logic hit_ctrl;
	logic hit_stat;
	logic sw_up;
	logic sw_dn;
	logic do_up;
	logic do_dn;
	logic [31:0] stat_word;
	logic [31:0] rd_word;
	localparam int unsigned BTN_N = 2;
	logic [1:0] btn_lvl;
	logic [1:0] btn_pulse;
	logic pready_r;
	logic [31:0] prdata_nxt;
	logic pslverr_nxt;
	logic en_nxt;
	logic ans_go;

	// both buttons share one detector shape
	assign btn_lvl = {step_down_in, step_up_in};

	for (genvar g = 0; g < BTN_N; g++) begin : g_btn
		pwmds_edge u_pwmds_edge (
			.clk_in(core_clk_in),
			.rst_in(rst_in),
			.level_in(btn_lvl[g]),
			.pulse_out(btn_pulse[g])
		);
	end

	assign up_pulse = btn_pulse[0];
	assign dn_pulse = btn_pulse[1];

	// illegal low values held at minimum
	assign div_eff = (divisor_in < pwmds_pkg::DIV_MIN) ? pwmds_pkg::DIV_MIN : divisor_in;

	// divide clock by divisor
	// a lowered divisor wraps at once rather than running out a long period
	assign cnt_wrap = (cnt_r >= div_eff - 6'h01);
	assign cnt_nxt = cnt_wrap ? 6'h00 : cnt_r + 6'h01;

	// one pwm period per divisor cycles
	// high while cnt*10 < lvl*div, so high time is lvl*div/10 cycles rounded up to a whole cycle
	assign phase_x10 = {4'h0, cnt_r} * {6'h00, pwmds_pkg::LVL_STEPS};
	assign high_lim = {4'h0, div_eff} * {6'h00, lvl_r};
	assign pwm_nxt = en_r & (phase_x10 < high_lim);

	// apb decode
	assign acc = psel_in & penable_in;
	assign wr_take = acc & pready_out & pwrite_in;
	assign hit_ctrl = (paddr_in == pwmds_pkg::ADDR_CTRL);
	assign hit_stat = (paddr_in == pwmds_pkg::ADDR_STAT);
	assign sw_up = wr_take & hit_ctrl & pwdata_in[pwmds_pkg::CTRL_UP_BIT];
	assign sw_dn = wr_take & hit_ctrl & pwdata_in[pwmds_pkg::CTRL_DN_BIT];
	assign apb_nxt = (acc && apb_r == pwmds_pkg::PWMDS_IDLE) ?
		pwmds_pkg::PWMDS_ACK : pwmds_pkg::PWMDS_IDLE;

	assign do_up = up_pulse | sw_up;
	assign do_dn = dn_pulse | sw_dn;

	// clamp at both ends; opposing steps together cancel
	always_comb begin
		lvl_nxt = lvl_r;
		case ({do_up, do_dn})
			2'b10: begin
				if (lvl_r < pwmds_pkg::LVL_MAX) begin
					lvl_nxt = lvl_r + 4'h1;
				end
			end
			2'b01: begin
				if (lvl_r != 4'h0) begin
					lvl_nxt = lvl_r - 4'h1;
				end
			end
			default: begin
				lvl_nxt = lvl_r;
			end
		endcase
	end

	always_comb begin
		stat_word = 32'h0000_0000;
		stat_word[pwmds_pkg::STAT_LVL_LSB +: pwmds_pkg::LVL_W] = lvl_r;
		stat_word[pwmds_pkg::STAT_DIV_LSB +: pwmds_pkg::DIV_W] = div_eff;
		stat_word[pwmds_pkg::STAT_PWM_BIT] = pwm_r;
		stat_word[pwmds_pkg::STAT_EN_BIT] = en_r;
	end

	assign rd_word = hit_stat ? stat_word :
		(hit_ctrl ? {31'h0000_0000, en_r} : 32'h0000_0000);

	// zero outside the answer cycle so stale reads never linger on the bus
	assign ans_go = (apb_nxt == pwmds_pkg::PWMDS_ACK);
	assign prdata_nxt = ans_go ? rd_word : 32'h0000_0000;
	assign pslverr_nxt = ans_go & ~(hit_ctrl | hit_stat);
	assign en_nxt = (wr_take && hit_ctrl) ? pwdata_in[pwmds_pkg::CTRL_EN_BIT] : en_r;

	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			cnt_r <= 6'h00;
		end else begin
			cnt_r <= cnt_nxt;
		end
	end

	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			lvl_r <= pwmds_pkg::LVL_RST;
		end else begin
			lvl_r <= lvl_nxt;
		end
	end

	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			pwm_r <= 1'b0;
		end else begin
			pwm_r <= pwm_nxt;
		end
	end

	// one wait state keeps every apb output registered
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			apb_r <= pwmds_pkg::PWMDS_IDLE;
		end else begin
			apb_r <= apb_nxt;
		end
	end

	// ready from its own flop, not decoded from state
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			pready_r <= 1'b0;
		end else begin
			pready_r <= ans_go;
		end
	end

	// read data for the answer cycle
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			prdata_r <= 32'h0000_0000;
		end else begin
			prdata_r <= prdata_nxt;
		end
	end

	// error for unmapped addresses
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			pslverr_r <= 1'b0;
		end else begin
			pslverr_r <= pslverr_nxt;
		end
	end

	// output enable, on after reset
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			en_r <= pwmds_pkg::CTRL_EN_RST;
		end else begin
			en_r <= en_nxt;
		end
	end

	assign pwm_out = pwm_r;
	assign pready_out = pready_r;
	assign prdata_out = prdata_r;
	assign pslverr_out = pslverr_r;
endmodule

// [tb/pwmds_load.sv]
// downstream load model counting pwm high cycles
`timescale 1ns/1ps
module pwmds_load (
	// clock, clear and pwm in
	input wire logic clk_in,
	input wire logic clr_in,
	input wire logic pwm_in,
	output logic [11:0] high_out
);
	always_ff @(posedge clk_in) begin
		high_out <= clr_in ? 12'h000 : high_out + {11'h000, pwm_in};
	end
endmodule

// [tb/pwmds_top_sva.sv]
// port checker for the pwm stepper
`timescale 1ns/1ps
module pwmds_chk (
	input wire logic core_clk_in,
	input wire logic rst_in,
	input wire logic pwm_out,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pready_out,
	input wire logic pslverr_out,
	input wire logic [31:0] prdata_out
);
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (rst_in);
	sequence acc_s;
		psel_in && $rose(penable_in);
	endsequence
	rst_quiet_a: assert property (disable iff (1'b0) rst_in ##1 rst_in |-> !pwm_out)
		else $error("pwm high in reset");
	start_high_a: assert property ($fell(rst_in) |=> pwm_out)
		else $error("pwm low after reset");
	apb_wait_a: assert property (acc_s |-> !pready_out ##1 pready_out ##1 !pready_out)
		else $error("apb wait state wrong");
	rst_apb_a: assert property (disable iff (1'b0)
		rst_in ##1 rst_in |-> !pready_out && !pslverr_out && prdata_out == 32'h0000_0000)
		else $error("apb output active in reset");
	err_ready_a: assert property (pslverr_out |-> pready_out)
		else $error("slave error without ready");
	rdata_idle_a: assert property (!pready_out |-> prdata_out == 32'h0000_0000)
		else $error("read data outside answer");
	sequence rsp_s;
		pready_out && psel_in && penable_in;
	endsequence
	ready_access_a: assert property (pready_out |-> rsp_s)
		else $error("ready outside access phase");
endmodule
bind pwmds_top pwmds_chk u_pwmds_chk (.core_clk_in, .rst_in, .pwm_out, .psel_in,
	.penable_in, .pready_out, .pslverr_out, .prdata_out);

// [tb/pwmds_top_tb.sv]
// self-checking bench for the pwm stepper
`timescale 1ns/1ps
module pwmds_top_tb;
	logic clk = 0, rst = 1, up = 0, dn = 0, sel = 0, en = 0, wr = 0, clr = 1, rdy, err, pwm, se;
	logic [5:0] dv = 6'h0A;
	logic [7:0] ad = 8'h00;
	logic [31:0] wd = 32'h0, rd, prd;
	logic [11:0] hi;
	int fail_count = 0, num_checks = 0;
	pwmds_top u_pwmds_top (.core_clk_in(clk), .rst_in(rst), .step_up_in(up),
		.step_down_in(dn), .divisor_in(dv), .pwm_out(pwm), .psel_in(sel), .penable_in(en),
		.pwrite_in(wr), .paddr_in(ad), .pwdata_in(wd), .prdata_out(prd), .pready_out(rdy),
		.pslverr_out(err));
	pwmds_load u_pwmds_load (.clk_in(clk), .clr_in(clr), .pwm_in(pwm), .high_out(hi));
	initial forever #20 clk = ~clk;
	task test_done;
		$display("checks %0d fails %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task chk(input string n, input logic [11:0] e, g);
		num_checks++;
		if (g !== e) begin
			fail_count++;
			$display("ERROR %s exp %0h got %0h", n, e, g);
		end
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		i = 0;
		sel <= 1;
		wr <= w;
		ad <= a;
		wd <= d;
		@(posedge clk);
		en <= 1;
		do begin
			@(posedge clk);
			i++;
		end while (rdy !== 1'b1 && i < 20);
		rd = prd;
		se = err;
		sel <= 0;
		en <= 0;
		@(posedge clk);
		if (i >= 20) begin
			fail_count++;
			test_done;
		end
	endtask
	task press(input logic u, input int h);
		up <= u;
		dn <= !u;
		repeat (h) @(posedge clk);
		up <= 0;
		dn <= 0;
		@(posedge clk);
	endtask
	// window spans whole periods, so high count is exact
	task duty(input logic [11:0] e);
		clr <= 0;
		repeat (50) @(posedge clk);
		clr <= 1;
		@(posedge clk);
		chk("high", e, hi);
		$display("test done");
	endtask
	initial begin
		repeat (5) @(posedge clk);
		rst <= 0;
		apb(0, pwmds_pkg::ADDR_STAT, 0);
		chk("level", {8'h00, pwmds_pkg::LVL_RST}, {8'h00, rd[3:0]});
		duty(12'h019);
		repeat (6) press(1, 1);
		duty(12'h032);
		repeat (3) press(0, 1);
		duty(12'h023);
		press(1, 8);
		duty(12'h028);
		repeat (9) apb(1, pwmds_pkg::ADDR_CTRL, 32'h5);
		duty(12'h000);
		apb(1, pwmds_pkg::ADDR_CTRL, 32'h3);
		duty(12'h005);
		dv <= 6'h05;
		repeat (2) @(posedge clk);
		duty(12'h00A);
		dv <= 6'h02;
		repeat (2) @(posedge clk);
		duty(12'h019);
		apb(0, pwmds_pkg::ADDR_STAT, 0);
		chk("divisor", 12'h002, {6'h00, rd[pwmds_pkg::STAT_DIV_LSB +: 6]});
		apb(1, pwmds_pkg::ADDR_CTRL, 32'h0);
		apb(0, pwmds_pkg::ADDR_CTRL, 0);
		chk("enable", 12'h000, {11'h000, rd[pwmds_pkg::CTRL_EN_BIT]});
		duty(12'h000);
		apb(1, pwmds_pkg::ADDR_CTRL, 32'h1);
		apb(0, 8'h08, 0);
		chk("slverr", 12'h001, {11'h000, se});
		rst <= 1;
		repeat (2) @(posedge clk);
		rst <= 0;
		apb(0, pwmds_pkg::ADDR_STAT, 0);
		chk("level", {8'h00, pwmds_pkg::LVL_RST}, {8'h00, rd[3:0]});
		chk("enable", 12'h001, {11'h000, rd[pwmds_pkg::STAT_EN_BIT]});
		duty(12'h019);
		test_done;
	end
endmodule
